// File: design/eiu_params.svh
// Constants of the external interrupt unit: offsets, field positions, resets, vectors
`ifndef EIU_PARAMS_SVH
`define EIU_PARAMS_SVH
`define EIU_OFS_MCU_CTRL   8'h00
`define EIU_OFS_INT_MASK   8'h04
`define EIU_OFS_INT_FLAGS  8'h08
`define EIU_OFS_PC_MASK    8'h0C
`define EIU_OFS_CORE_CTRL  8'h10
`define EIU_OFS_STATUS     8'h14
`define EIU_OFS_IRQ_STAT   8'h18
`define EIU_OFS_IRQ_MASK   8'h1C
`define EIU_RST_MCU_CTRL   8'h00
`define EIU_RST_INT_MASK   8'h00
`define EIU_RST_PC_MASK    6'h3F
`define EIU_BIT_EXT        6
`define EIU_BIT_PC         5
`define EIU_MCU_WMASK      8'h7B
`define EIU_VEC_RESET      4'h0
`define EIU_VEC_EXT        4'h1
`define EIU_VEC_PC         4'h2
`define EIU_VEC_LAST       4'hE
`endif

// File: design/eiu_pkg.sv
// Types of the external interrupt unit
package eiu_pkg;
    typedef enum logic [1:0]
    {
        EIU_SENSE_LOW    = 2'h0,
        EIU_SENSE_CHANGE = 2'h1,
        EIU_SENSE_FALL   = 2'h2,
        EIU_SENSE_RISE   = 2'h3
    } eiu_sense_t;
    typedef enum logic [1:0]
    {
        EIU_BUS_IDLE = 2'b01,
        EIU_BUS_DATA = 2'b10
    } eiu_bus_st_t;
endpackage : eiu_pkg

// File: design/eiu_pin_detect.sv
// Sense detector for the external interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "eiu_params.svh"
module eiu_pin_detect
    import eiu_pkg::*;
(
    input  wire logic       clk_i,     // System clock
    input  wire logic       arst_n_i,  // Async reset, active low
    input  wire logic       pin_i,     // External pin level
    input  wire logic [1:0] sense_i,   // Sense control
    output logic            level_o,   // Pin low, combinational
    output logic            edge_o     // Selected edge seen, pulse
);
    typedef struct packed
    {
        logic smp;
        logic prev;
        logic evt;
    } eiu_det_state_t;
    eiu_det_state_t st_reg;
    eiu_det_state_t st_next;
    always_comb
    begin
        st_next      = st_reg;
        st_next.smp  = pin_i;
        st_next.prev = st_reg.smp;
        unique case (eiu_sense_t'(sense_i))
            EIU_SENSE_CHANGE: st_next.evt = st_reg.smp ^ st_reg.prev;
            EIU_SENSE_FALL:   st_next.evt = st_reg.prev & ~st_reg.smp;
            EIU_SENSE_RISE:   st_next.evt = ~st_reg.prev & st_reg.smp;
            EIU_SENSE_LOW:    st_next.evt = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_reg <= '{smp: 1'b1, prev: 1'b1, evt: 1'b0};
        else
            st_reg <= st_next;
    end
    assign level_o = ~pin_i;
    assign edge_o  = st_reg.evt;
endmodule : eiu_pin_detect
`default_nettype wire

// File: design/eiu_pc_detect.sv
// Pin change detector for the masked pin change inputs
`timescale 1ns/1ps
`default_nettype none
module eiu_pc_detect
    import eiu_pkg::*;
#(
    parameter int N = 6
)
(
    input  wire logic         clk_i,     // System clock
    input  wire logic         arst_n_i,  // Async reset, active low
    input  wire logic [N-1:0] pins_i,    // Pin change inputs
    input  wire logic [N-1:0] mask_i,    // Per pin enables
    output logic              change_o   // Enabled pin toggled
);
    typedef struct packed
    {
        logic [N-1:0] prev;
        logic         init;
    } eiu_pc_state_t;
    eiu_pc_state_t st_reg;
    eiu_pc_state_t st_next;
    if (N < 1 || N > 8)
    begin : g_width_check
        $error("N out of range");
    end
    always_comb
    begin
        st_next      = st_reg;
        st_next.prev = pins_i;
        st_next.init = 1'b1;
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    // Compare raw pins against last value, no sampling stage in front
    assign change_o = st_reg.init & (|((pins_i ^ st_reg.prev) & mask_i));
endmodule : eiu_pc_detect
`default_nettype wire

// File: design/eiu_top.sv
// External interrupt unit with AHB-Lite registers and vector request logic
//
// Overview of operation
// - After any reset the fetch address output is vector 0x0000.
// - Vectors: 0x0001 external pin, 0x0002 pin change, others up to 0x000E.
// - Interrupts trigger from pin levels even when pins are driven as outputs.
// - Any unmasked pin change input toggling raises the pin change request.
// - Pin changes are seen directly from pin levels without sampling stages.
// - Sense bits: 00 low, 01 any change, 10 falling, 11 rising.
// - Level mode keeps requesting while the pin stays low and enabled.
// - Edge modes need the clock; low level is detected combinationally.
// - Edge modes sample the pin first; pulses over one clock always detected.
// - A low level gone before start-up ends makes no vector request, but still sets irq_stat bit 1.
// - External interrupt enabled by mask bit 6 and global flag.
// - Pin change interrupt enabled by mask bit 5 and global flag.
// - Flag bit 6 set by edge, cleared by vector or writing one.
// - In level mode the external flag is held cleared.
// - Flag bit 5 set by pin change, cleared by vector or writing one.
// - Pin change mask bits 5..0 reset to one; bits 7, 6 read zero.
// - Mask and flag register bits 7, 4..0 read zero, ignore writes.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "eiu_params.svh"
module eiu_top
    import eiu_pkg::*;
#(
    parameter int PC_PINS = 6
)
(
    input  wire logic        clk_i,          // System clock, 40 MHz
    input  wire logic        arst_n_i,       // Async reset, active low
    input  wire logic        hsel_i,         // AHB select
    input  wire logic [7:0]  haddr_i,        // AHB address
    input  wire logic [1:0]  htrans_i,       // AHB transfer type
    input  wire logic        hwrite_i,       // AHB write
    input  wire logic [2:0]  hsize_i,        // AHB size
    input  wire logic        hready_i,       // AHB bus ready
    input  wire logic [31:0] hwdata_i,       // AHB write data
    output logic [31:0]      hrdata_o,       // AHB read data
    output logic             hreadyout_o,    // AHB ready out
    output logic             hresp_o,        // AHB response, OKAY
    input  wire logic        ext_irq_pin_i,  // External interrupt pin
    input  wire logic [5:0]  pin_change_inputs_i, // Pin change pins
    input  wire logic        core_status_i,  // Core global interrupt flag
    input  wire logic        startup_done_i, // Wake start-up time over
    input  wire logic        vec_ack_i,      // Core takes the vector, pulse
    output logic             irq_req_o,      // Request to core
    output logic [3:0]       irq_vec_o,      // Vector of request
    output logic             wake_o,         // Clockless wake request
    output logic             irq_o           // Bus interrupt line
);
    typedef struct packed
    {
        eiu_bus_st_t bst;
        logic [7:0]  addr;
        logic        wr;
        logic [7:0]  mcu_control;
        logic [7:0]  interrupt_mask;
        logic [1:0]  flags;
        logic [5:0]  pin_change_mask;
        logic        gie_sw;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
        logic        req;
        logic [3:0]  vec;
    } eiu_state_t;
    eiu_state_t st_reg;
    eiu_state_t st_next;
    logic       lvl_low;
    logic       ext_edge;
    logic       pc_change;
    logic       ext_en;
    logic       pc_en;
    logic       lvl_mode;
    logic       ext_active;
    logic       pc_active;
    logic       wr_flags;
    logic       ack_ext;
    logic       ack_pc;
    logic [7:0] wb;
    // The pin change detector and the mask register are built for six pins
    if (PC_PINS != 6)
    begin : g_pins_check
        $error("PC_PINS must be 6");
    end
    function automatic logic [31:0] rd_word(input eiu_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            `EIU_OFS_MCU_CTRL:  r[7:0] = s.mcu_control;
            `EIU_OFS_INT_MASK:  r[7:0] = s.interrupt_mask;
            `EIU_OFS_INT_FLAGS: r[7:0] = {1'b0, s.flags, 5'h00};
            `EIU_OFS_PC_MASK:   r[7:0] = {2'b00, s.pin_change_mask};
            `EIU_OFS_CORE_CTRL: r[0]   = s.gie_sw;
            `EIU_OFS_STATUS:    r[3:0] = {s.req, lvl_mode, ~ext_irq_pin_i, core_status_i};
            `EIU_OFS_IRQ_STAT:  r[1:0] = s.irq_stat;
            `EIU_OFS_IRQ_MASK:  r[1:0] = s.irq_mask;
            default:            r      = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_word
    eiu_pin_detect u_pin
    (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .pin_i    (ext_irq_pin_i),
        .sense_i  (st_reg.mcu_control[1:0]),
        .level_o  (lvl_low),
        .edge_o   (ext_edge)
    );
    eiu_pc_detect #(.N(PC_PINS)) u_pc
    (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .pins_i   (pin_change_inputs_i),
        .mask_i   (st_reg.pin_change_mask),
        .change_o (pc_change)
    );
    assign lvl_mode   = (st_reg.mcu_control[1:0] == 2'b00);
    assign ext_en     = st_reg.interrupt_mask[`EIU_BIT_EXT] & core_status_i;
    assign pc_en      = st_reg.interrupt_mask[`EIU_BIT_PC] & core_status_i;
    // Level source only counts once start-up is over and the pin is still low
    assign ext_active = lvl_mode ? (lvl_low & startup_done_i)
                                 : st_reg.flags[1];
    assign pc_active  = st_reg.flags[0];
    assign wake_o     = (st_reg.interrupt_mask[`EIU_BIT_EXT] & lvl_mode & lvl_low)
                      | (st_reg.interrupt_mask[`EIU_BIT_PC] & pc_change);
    assign wr_flags   = (st_reg.bst == EIU_BUS_DATA) & st_reg.wr
                      & (st_reg.addr == `EIU_OFS_INT_FLAGS);
    assign ack_ext    = vec_ack_i & st_reg.req & (st_reg.vec == `EIU_VEC_EXT);
    assign ack_pc     = vec_ack_i & st_reg.req & (st_reg.vec == `EIU_VEC_PC);
    assign wb         = hwdata_i[7:0];
    always_comb
    begin
        st_next = st_reg;
        // Bus address phase, zero wait states
        if (hsel_i && hready_i && htrans_i[1])
        begin
            st_next.bst   = EIU_BUS_DATA;
            st_next.addr  = {haddr_i[7:2], 2'b00};
            st_next.wr    = hwrite_i;
            st_next.rdata = hwrite_i ? st_reg.rdata : rd_word(st_reg, {haddr_i[7:2], 2'b00});
        end
        else
        begin
            st_next.bst = EIU_BUS_IDLE;
        end
        if (st_reg.bst == EIU_BUS_DATA && st_reg.wr)
        begin
            unique case (st_reg.addr)
                `EIU_OFS_MCU_CTRL:  st_next.mcu_control = wb & `EIU_MCU_WMASK;
                `EIU_OFS_INT_MASK:  st_next.interrupt_mask = {1'b0, wb[6:5], 5'h00};
                `EIU_OFS_PC_MASK:   st_next.pin_change_mask = wb[5:0];
                `EIU_OFS_CORE_CTRL: st_next.gie_sw = wb[0];
                `EIU_OFS_IRQ_STAT:  st_next.irq_stat = st_reg.irq_stat & ~wb[1:0];
                `EIU_OFS_IRQ_MASK:  st_next.irq_mask = wb[1:0];
                default:            st_next.gie_sw = st_reg.gie_sw;
            endcase
        end
        // Flags: clear by write-one or vector, set wins over clear
        if ((wr_flags && wb[`EIU_BIT_EXT]) || ack_ext)
            st_next.flags[1] = 1'b0;
        if (ext_edge)
            st_next.flags[1] = 1'b1;
        if (lvl_mode)
            st_next.flags[1] = 1'b0;
        if ((wr_flags && wb[`EIU_BIT_PC]) || ack_pc)
            st_next.flags[0] = 1'b0;
        if (pc_change)
            st_next.flags[0] = 1'b1;
        if (ext_edge || (lvl_mode && lvl_low))
            st_next.irq_stat[1] = 1'b1;
        if (pc_change)
            st_next.irq_stat[0] = 1'b1;
        // Priority: lower vector number first
        st_next.req = 1'b0;
        st_next.vec = `EIU_VEC_RESET;
        if (ext_en && ext_active && !ack_ext)
        begin
            st_next.req = 1'b1;
            st_next.vec = `EIU_VEC_EXT;
        end
        else if (pc_en && pc_active && !ack_pc)
        begin
            st_next.req = 1'b1;
            st_next.vec = `EIU_VEC_PC;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_reg                 <= '0;
            st_reg.bst             <= EIU_BUS_IDLE;
            st_reg.mcu_control     <= `EIU_RST_MCU_CTRL;
            st_reg.interrupt_mask  <= `EIU_RST_INT_MASK;
            st_reg.pin_change_mask <= `EIU_RST_PC_MASK;
            st_reg.vec             <= `EIU_VEC_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
    assign hrdata_o    = st_reg.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign irq_req_o   = st_reg.req;
    assign irq_vec_o   = st_reg.vec;
    assign irq_o       = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule : eiu_top
`default_nettype wire

// File: sim/eiu_chk.sv
// Port checker for the external interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "eiu_params.svh"
module eiu_chk
    import eiu_pkg::*;
(
    input wire logic        clk_i,          // clock
    input wire logic        arst_n_i,       // reset
    input wire logic        hsel_i,         // select
    input wire logic [7:0]  haddr_i,        // address
    input wire logic [1:0]  htrans_i,       // transfer
    input wire logic        hwrite_i,       // write
    input wire logic        hready_i,       // ready
    input wire logic [31:0] hwdata_i,       // write data
    input wire logic        ext_irq_pin_i,  // pin
    input wire logic        core_status_i,  // global flag
    input wire logic        startup_done_i, // start-up over
    input wire logic        vec_ack_i,      // acknowledge
    input wire logic        irq_req_o,      // request
    input wire logic [3:0]  irq_vec_o,      // vector
    input wire logic        wake_o          // wake
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic       wp_reg;
    logic [7:0] wa_reg;
    logic [7:0] msk_reg;
    logic [1:0] sns_reg;
    logic       lvl;
    // Shadow of mask and sense bits, updated at the data phase edge
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
        begin
            wp_reg  <= 1'b0;
            wa_reg  <= 8'h00;
            msk_reg <= 8'h00;
            sns_reg <= 2'h0;
        end
        else
        begin
            wp_reg <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
            wa_reg <= haddr_i;
            if (wp_reg && wa_reg == `EIU_OFS_INT_MASK)
                msk_reg <= hwdata_i[7:0];
            if (wp_reg && wa_reg == `EIU_OFS_MCU_CTRL)
                sns_reg <= hwdata_i[1:0];
        end
    assign lvl = sns_reg == 2'h0 && msk_reg[6] && !ext_irq_pin_i && core_status_i
                 && startup_done_i && !vec_ack_i;
    sequence s_rise;
        sns_reg == 2'h3 && msk_reg[6] && core_status_i && $rose(ext_irq_pin_i);
    endsequence
    sequence s_ext; irq_req_o && irq_vec_o == `EIU_VEC_EXT; endsequence
    property p_idle; !irq_req_o |-> irq_vec_o == `EIU_VEC_RESET; endproperty
    a_idle: assert property (p_idle) else $error("vector without request");
    property p_vec; irq_req_o |-> irq_vec_o inside {`EIU_VEC_EXT, `EIU_VEC_PC}; endproperty
    a_vec: assert property (p_vec) else $error("vector out of table");
    property p_gie; !core_status_i |=> !irq_req_o; endproperty
    a_gie: assert property (p_gie) else $error("request with global flag off");
    property p_mask; (msk_reg[6:5] == 2'b00) [*2] |-> !irq_req_o; endproperty
    a_mask: assert property (p_mask) else $error("request while disabled");
    property p_ack; irq_req_o && vec_ack_i && irq_vec_o == 4'h2 |=> irq_vec_o != 4'h2; endproperty
    a_ack: assert property (p_ack) else $error("request stays after ack");
    property p_level; lvl [*2] |-> s_ext; endproperty
    a_level: assert property (p_level) else $error("low level not requested");
    property p_wake;
        sns_reg == 2'h0 && msk_reg[6] && core_status_i && !ext_irq_pin_i |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on low level");
    property p_rise; s_rise |-> ##[1:6] s_ext; endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");
endmodule : eiu_chk
bind eiu_top eiu_chk eiu_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hwdata_i(hwdata_i), .ext_irq_pin_i(ext_irq_pin_i), .core_status_i(core_status_i),
    .startup_done_i(startup_done_i), .vec_ack_i(vec_ack_i), .irq_req_o(irq_req_o),
    .irq_vec_o(irq_vec_o), .wake_o(wake_o));
`default_nettype wire

// File: sim/eiu_core_model.sv
// Core side model: takes requests after a delay and keeps the vector
`timescale 1ns/1ps
`default_nettype none
module eiu_core_model
(
    input  wire logic       clk_i,      // clock
    input  wire logic       arst_n_i,   // reset
    input  wire logic       irq_req_i,  // request
    input  wire logic [3:0] irq_vec_i,  // vector
    input  wire logic       ack_en_i,   // core accepts
    input  wire logic [3:0] dly_i,      // wait before ack
    output logic            vec_ack_o,  // ack pulse
    output logic [3:0]      last_vec_o, // vector taken
    output logic [7:0]      n_ack_o     // acks given
);
    logic [3:0] wait_reg;
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
        begin
            vec_ack_o  <= 1'b0;
            last_vec_o <= 4'h0;
            n_ack_o    <= 8'h00;
            wait_reg   <= 4'h0;
        end
        else if (vec_ack_o || !irq_req_i || !ack_en_i)
        begin
            vec_ack_o <= 1'b0;
            wait_reg  <= 4'h0;
        end
        else if (wait_reg == dly_i)
        begin
            vec_ack_o  <= 1'b1;
            last_vec_o <= irq_vec_i;
            n_ack_o    <= n_ack_o + 8'h01;
        end
        else
            wait_reg <= wait_reg + 4'h1;
endmodule : eiu_core_model
`default_nettype wire

// File: sim/eiu_top_tb.sv
// Testbench of the external interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "eiu_params.svh"
module eiu_top_tb
    import eiu_pkg::*;
;
    logic        clk_i, arst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin = 1'b1;
    logic        gie = 1'b0, sud = 1'b1, ack_en = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [5:0]  pcin = 6'h00;
    logic [3:0]  dly = 4'h0;
    logic [31:0] hwdata = 32'h0, rd, hrdata;
    logic        hrdy, hresp, req, wake, irq, ack;
    logic [3:0]  vec, last_vec;
    logic [7:0]  n_ack;
    int          n_fail = 0, n_tests = 0;
    eiu_top eiu_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .ext_irq_pin_i(pin), .pin_change_inputs_i(pcin), .core_status_i(gie),
        .startup_done_i(sud), .vec_ack_i(ack), .irq_req_o(req), .irq_vec_o(vec),
        .wake_o(wake), .irq_o(irq));
    eiu_core_model eiu_core_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_req_i(req),
        .irq_vec_i(vec), .ack_en_i(ack_en), .dly_i(dly), .vec_ack_o(ack),
        .last_vec_o(last_vec), .n_ack_o(n_ack));
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        rd = hrdata;
        #1;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task automatic setp(input logic p, input logic [5:0] c);
        @(posedge clk_i);
        pin  <= p;
        pcin <= c;
        repeat (6) @(posedge clk_i);
        #1;
    endtask : setp
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rdc("mcu_control", `EIU_OFS_MCU_CTRL, 32'h0);
        rdc("interrupt_mask", `EIU_OFS_INT_MASK, 32'h0);
        rdc("pin_change_mask", `EIU_OFS_PC_MASK, 32'h3F);
        chk("vector", 32'h0, {28'h0, vec});
        bus(1'b1, `EIU_OFS_INT_MASK, 32'hFF);
        rdc("interrupt_mask", `EIU_OFS_INT_MASK, 32'h60);
        bus(1'b1, `EIU_OFS_PC_MASK, 32'hFF);
        rdc("pin_change_mask", `EIU_OFS_PC_MASK, 32'h3F);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("status", `EIU_OFS_STATUS, 32'h4);
        bus(1'b1, `EIU_OFS_CORE_CTRL, 32'h1);
        rdc("core_ctrl", `EIU_OFS_CORE_CTRL, 32'h1);
        bus(1'b1, `EIU_OFS_MCU_CTRL, 32'hFF);
        rdc("mcu_control", `EIU_OFS_MCU_CTRL, 32'h7B);
        chk("hresp", 32'h0, {31'h0, hresp});
        bus(1'b1, `EIU_OFS_INT_MASK, 32'h40);
        @(posedge clk_i);
        gie <= 1'b1;
        // Each edge mode: no selected edge first (a rising one in falling mode), then the selected one
        for (int m = 1; m < 4; m++)
        begin
            bus(1'b1, `EIU_OFS_MCU_CTRL, 32'(m));
            bus(1'b1, `EIU_OFS_INT_FLAGS, 32'h60);
            setp(m != 3, 6'h0);
            rdc("flags idle", `EIU_OFS_INT_FLAGS, 32'h0);
            setp(m == 3, 6'h0);
            rdc("flags edge", `EIU_OFS_INT_FLAGS, 32'h40);
            chk("vector", 32'h1, {28'h0, vec});
            bus(1'b1, `EIU_OFS_INT_FLAGS, 32'h40);
            rdc("flags cleared", `EIU_OFS_INT_FLAGS, 32'h0);
        end
        bus(1'b1, `EIU_OFS_MCU_CTRL, 32'h0);
        @(posedge clk_i);
        sud <= 1'b0;
        setp(1'b0, 6'h0);
        setp(1'b1, 6'h0);
        @(posedge clk_i);
        sud    <= 1'b1;
        ack_en <= 1'b1;
        dly    <= 4'h3;
        setp(1'b1, 6'h0);
        chk("early low", 32'h0, {24'h0, n_ack});
        setp(1'b0, 6'h0);
        chk("wake", 32'h1, {31'h0, wake});
        rdc("flags level", `EIU_OFS_INT_FLAGS, 32'h0);
        chk("taken", 32'h1, {28'h0, last_vec});
        setp(1'b1, 6'h0);
        @(posedge clk_i);
        ack_en <= 1'b0;
        bus(1'b1, `EIU_OFS_PC_MASK, 32'h01);
        bus(1'b1, `EIU_OFS_INT_MASK, 32'h20);
        bus(1'b1, `EIU_OFS_IRQ_STAT, 32'h3);
        setp(1'b1, 6'h02);
        rdc("pc masked", `EIU_OFS_INT_FLAGS, 32'h0);
        setp(1'b1, 6'h03);
        rdc("pc flag", `EIU_OFS_INT_FLAGS, 32'h20);
        chk("pc vector", 32'h2, {28'h0, vec});
        rdc("irq_stat", `EIU_OFS_IRQ_STAT, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `EIU_OFS_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, `EIU_OFS_IRQ_STAT, 32'h1);
        chk("irq off", 32'h0, {31'h0, irq});
        @(posedge clk_i);
        ack_en <= 1'b1;
        setp(1'b1, 6'h03);
        rdc("pc acked", `EIU_OFS_INT_FLAGS, 32'h0);
        chk("pc taken", 32'h2, {28'h0, last_vec});
        close_out();
    end
endmodule : eiu_top_tb
`default_nettype wire
